// file: rtl/standard_timer.sv
// Summary of operation
// - Comparator A and comparator P matches each give their own event.
// - A compare match can clear the counter and change the output pin.
// - External pin as clock counts on its rising or falling edge.
// - Single pulse mode uses the external pin as the start trigger.
// - Compare mode drives the pin high, low or toggles on a match.
// - PWM mode puts the generated waveform on the output pin.
// - High bytes go direct; low bytes pass through one shared byte buffer.
// - Low write fills buffer; high write stores high and copies buffer low.
// - High read returns high and loads low into buffer; low read returns buffer.
// - The core is a 16-bit up counter fed by the chosen clock.
// - Comparator P holds 8 bits and checks the counter top byte.
// - Comparator A holds 16 bits and checks the whole counter.
// - Software only clears the counter, by raising the enable bit.
// - Counter clears itself on overflow or a selected comparator match.
// - Counter is a read-only byte pair; comparator A is read/write.
// - Four modes: compare output, timer, single pulse, PWM.
// - Clock select picks sys/4, sys, H/16, H/64, sub, sub, pin rise, fall.
// - Enable rise clears counter and restores pin; enable fall keeps count.
// - Mode field: compare output, undefined, PWM or single pulse, timer.
// - Outside PWM, clear select set clears on match A, else on match P or overflow; in PWM the swap bit picks.
module standard_timer #(
   parameter int ADDR_W = 8
) (
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic              sub_clock_tick,
   input  wire logic              timer_clock_pin,
   output logic                   timer_wave_pin,
   output logic                   match_a_event,
   output logic                   match_p_event
);

   // Tells whether a byte address hits one of the seven registers.
   function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
      logic [7:0] a;
      a = addr[7:0];
      reg_hit = (a == timer_pkg::OFF_CTRL0) || (a == timer_pkg::OFF_CTRL1) ||
                (a == timer_pkg::OFF_COUNT_LO) || (a == timer_pkg::OFF_COUNT_HI) ||
                (a == timer_pkg::OFF_CMPA_LO) || (a == timer_pkg::OFF_CMPA_HI) ||
                (a == timer_pkg::OFF_PERIOD);
   endfunction

   timer_pkg::ctrl0_type ctrl0_r;
   timer_pkg::ctrl1_type ctrl1_r;
   logic [15:0]          counter_r;
   logic [15:0]          counter_nxt;
   logic [15:0]          cmpa_r;
   logic [7:0]           period_r;
   logic [7:0]           buffer_r;
   logic [5:0]           presc_r;
   logic                 pin_prev_r;
   logic                 pulse_r;
   logic                 pulse_nxt;
   logic                 wave_r;
   logic                 wave_nxt;
   logic                 pin_r;
   logic                 a_event_r;
   logic                 p_event_r;
   logic                 aw_full_r;
   logic [7:0]           aw_addr_r;
   logic                 w_full_r;
   logic [7:0]           w_data_r;
   logic                 w_strb_r;
   logic                 bvalid_r;
   logic [1:0]           bresp_r;
   logic                 rvalid_r;
   logic [1:0]           rresp_r;
   logic [31:0]          rdata_r;

   // Bus handshakes: one slot per write channel, so address and data come in any order.
   wire aw_take  = awvalid & awready;
   wire w_take   = wvalid & wready;
   wire ar_take  = arvalid & arready;
   wire do_write = aw_full_r & w_full_r & ~bvalid_r;
   wire wr_hit   = reg_hit(aw_addr_r);
   wire wr_en    = do_write & w_strb_r;
   wire [7:0] ra = araddr[7:0];

   assign awready = ~aw_full_r & ~bvalid_r;
   assign wready  = ~w_full_r & ~bvalid_r;
   assign arready = ~rvalid_r;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;
   assign rvalid  = rvalid_r;
   assign rresp   = rresp_r;
   assign rdata   = rdata_r;

   // Register write strobes; a write without byte lane 0 stores nothing.
   // no counter strobe
   wire wr_ctrl0   = wr_en & (aw_addr_r == timer_pkg::OFF_CTRL0);
   wire wr_ctrl1   = wr_en & (aw_addr_r == timer_pkg::OFF_CTRL1);
   wire wr_cmpa_lo = wr_en & (aw_addr_r == timer_pkg::OFF_CMPA_LO);
   wire wr_cmpa_hi = wr_en & (aw_addr_r == timer_pkg::OFF_CMPA_HI);
   wire wr_period  = wr_en & (aw_addr_r == timer_pkg::OFF_PERIOD);
   wire rd_cnt_hi  = ar_take & (ra == timer_pkg::OFF_COUNT_HI);
   wire rd_cmpa_hi = ar_take & (ra == timer_pkg::OFF_CMPA_HI);
   wire rd_low     = ar_take & ((ra == timer_pkg::OFF_COUNT_LO) |
                                (ra == timer_pkg::OFF_CMPA_LO));
   timer_pkg::ctrl0_type wr_ctrl0_val;
   assign wr_ctrl0_val = timer_pkg::ctrl0_type'(w_data_r);

   wire en_rise = wr_ctrl0 & wr_ctrl0_val.enable & ~ctrl0_r.enable;

   // Read data selection; the unused control bits and upper lanes read as zero.
   // low bytes via buffer
   wire [7:0] rd_byte =
      (ra == timer_pkg::OFF_CTRL0)    ? {ctrl0_r[7:3], 3'h0} :
      (ra == timer_pkg::OFF_CTRL1)    ? ctrl1_r :
      (ra == timer_pkg::OFF_COUNT_HI) ? counter_r[15:8] :
      (ra == timer_pkg::OFF_CMPA_HI)  ? cmpa_r[15:8] :
      (ra == timer_pkg::OFF_PERIOD)   ? period_r :
      (ra == timer_pkg::OFF_COUNT_LO) ? buffer_r :
      (ra == timer_pkg::OFF_CMPA_LO)  ? buffer_r : 8'h00;

   // Write channel slots and response.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         aw_full_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_full_r  <= 1'b0;
         w_data_r  <= 8'h00;
         w_strb_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= timer_pkg::RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= awaddr[7:0];
         end
         if (w_take) begin
            w_full_r <= 1'b1;
            w_data_r <= wdata[7:0];
            w_strb_r <= wstrb[0];
         end
         if (do_write) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
         end else if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Read channel; the answer stands from the same edge that takes the address.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rvalid_r <= 1'b0;
         rresp_r  <= timer_pkg::RESP_OKAY;
         rdata_r  <= 32'h0000_0000;
      end else if (ar_take) begin
         rvalid_r <= 1'b1;
         rresp_r  <= reg_hit(araddr) ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
         rdata_r  <= {24'h000000, rd_byte};
      end else if (rvalid_r && rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // Software-visible registers. A buffer write wins over a buffer load by a read in
   // the same cycle, since the write is the step software ordered last.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl0_r  <= timer_pkg::ctrl0_type'(timer_pkg::CTRL0_RST);
         ctrl1_r  <= timer_pkg::ctrl1_type'(timer_pkg::CTRL1_RST);
         cmpa_r   <= timer_pkg::CMPA_RST;
         period_r <= timer_pkg::PERIOD_RST;
         buffer_r <= timer_pkg::BUFFER_RST;
      end else begin
         if (wr_ctrl0) begin
            ctrl0_r <= {w_data_r[7:3], 3'h0};
         end
         if (wr_ctrl1) begin
            ctrl1_r <= timer_pkg::ctrl1_type'(w_data_r);
         end
         if (wr_period) begin
            period_r <= w_data_r;
         end
         if (wr_cmpa_hi) begin
            cmpa_r <= {w_data_r, buffer_r};
         end
         if (wr_cmpa_lo) begin
            buffer_r <= w_data_r;
         end else if (rd_cnt_hi) begin
            buffer_r <= counter_r[7:0];
         end else if (rd_cmpa_hi) begin
            buffer_r <= cmpa_r[7:0];
         end
      end
   end

   // Clock source selection. The high clock is taken as the system clock here.
   wire pin_rise  = timer_clock_pin & ~pin_prev_r;
   wire pin_fall  = ~timer_clock_pin & pin_prev_r;
   logic src_tick;
   always_comb begin
      unique case (ctrl0_r.clk_sel)
         timer_pkg::CLK_SYS_DIV4: src_tick = (presc_r[1:0] == timer_pkg::DIV4_MASK[1:0]);
         timer_pkg::CLK_SYS:      src_tick = 1'b1;
         timer_pkg::CLK_H_DIV16:  src_tick = (presc_r[3:0] == timer_pkg::DIV16_MASK[3:0]);
         timer_pkg::CLK_H_DIV64:  src_tick = (presc_r == timer_pkg::DIV64_MASK);
         timer_pkg::CLK_SUB_A:    src_tick = sub_clock_tick;
         timer_pkg::CLK_SUB_B:    src_tick = sub_clock_tick;
         timer_pkg::CLK_PIN_RISE: src_tick = pin_rise;
         timer_pkg::CLK_PIN_FALL: src_tick = pin_fall;
      endcase
   end

   // Counting conditions and the two comparators.
   wire        pwm_mode  = (ctrl1_r.mode == timer_pkg::MODE_PWM);
   wire        sp_mode   = pwm_mode & (ctrl1_r.pin_action == timer_pkg::PWM_SINGLE);
   wire        run       = ctrl0_r.enable & ~ctrl0_r.pause;
   wire        tick      = run & src_tick & (~sp_mode | pulse_r);
   wire [15:0] cnt_inc   = counter_r + 16'h0001;
   wire        match_a   = tick & (cnt_inc == cmpa_r);
   // top byte compare, zero period means overflow
   wire        match_p   = tick & (cnt_inc[15:8] == period_r) & (cnt_inc[7:0] == 8'h00);
   wire        sp_start  = sp_mode & run & pin_rise & ~pulse_r;
   wire        clear_hit = pwm_mode ? (ctrl1_r.swap ? match_a : match_p)
                                    : (ctrl1_r.clear_sel ? match_a : match_p);

   // Next counter value; there is no path that loads software data into it.
   // self clear on match
   always_comb begin
      counter_nxt = counter_r;
      pulse_nxt   = pulse_r;
      if (en_rise) begin
         counter_nxt = 16'h0000;
         pulse_nxt   = 1'b0;
      end else if (sp_start) begin
         counter_nxt = 16'h0000;
         pulse_nxt   = 1'b1;
      end else if (tick) begin
         counter_nxt = clear_hit ? 16'h0000 : cnt_inc;
         if (sp_mode && match_a) begin
            pulse_nxt = 1'b0;
         end
      end
   end

   // Output level before polarity. The duty comparator is the one not setting the period.
   wire duty_on = ctrl1_r.swap ? (counter_nxt[15:8] < period_r) : (counter_nxt < cmpa_r);
   wire active  = ctrl1_r.init_level;
   always_comb begin
      wave_nxt = wave_r;
      if (en_rise) begin
         wave_nxt = ctrl1_r.init_level;
      end else begin
         unique case (ctrl1_r.mode)
            timer_pkg::MODE_COMPARE: begin
               if (match_a) begin
                  unique case (ctrl1_r.pin_action)
                     timer_pkg::ACT_NONE:   wave_nxt = wave_r;
                     timer_pkg::ACT_LOW:    wave_nxt = 1'b0;
                     timer_pkg::ACT_HIGH:   wave_nxt = 1'b1;
                     timer_pkg::ACT_TOGGLE: wave_nxt = ~wave_r;
                  endcase
               end
            end
            timer_pkg::MODE_PWM: begin
               unique case (ctrl1_r.pin_action)
                  timer_pkg::PWM_INACTIVE: wave_nxt = ~active;
                  timer_pkg::PWM_ACTIVE:   wave_nxt = active;
                  timer_pkg::PWM_WAVE:     wave_nxt = (ctrl0_r.enable && duty_on) ? active
                                                                                  : ~active;
                  timer_pkg::PWM_SINGLE:   wave_nxt = pulse_nxt ? active : ~active;
               endcase
            end
            // The pin is left as it was in timer mode and on the undefined code.
            timer_pkg::MODE_TIMER: wave_nxt = wave_r;
            timer_pkg::MODE_UNDEF: wave_nxt = wave_r;
         endcase
      end
   end

   // Counter, prescaler, pin state and the two match events.
   // two match events
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         counter_r  <= timer_pkg::COUNT_RST;
         presc_r    <= timer_pkg::PRESC_RST;
         pin_prev_r <= 1'b0;
         pulse_r    <= 1'b0;
         wave_r     <= 1'b0;
         pin_r      <= 1'b0;
         a_event_r  <= 1'b0;
         p_event_r  <= 1'b0;
      end else begin
         counter_r  <= counter_nxt;
         presc_r    <= presc_r + 6'h01;
         pin_prev_r <= timer_clock_pin;
         pulse_r    <= pulse_nxt;
         wave_r     <= wave_nxt;
         pin_r      <= wave_nxt ^ (ctrl1_r.polarity & (ctrl1_r.mode != timer_pkg::MODE_TIMER));
         a_event_r  <= match_a;
         p_event_r  <= match_p;
      end
   end

   assign timer_wave_pin = pin_r;
   assign match_a_event  = a_event_r;
   assign match_p_event  = p_event_r;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   en_clears_count_a: assert property (en_rise |=> counter_r == 16'h0000)
      else $error("Enable rise did not clear the counter.");
   count_step_a: assert property (
      tick && !clear_hit && !en_rise && !sp_start |=> counter_r == $past(counter_r) + 16'h0001)
      else $error("Counter did not step by one.");
   count_hold_a: assert property (!run && !en_rise && !sp_start |=> $stable(counter_r))
      else $error("Counter moved while stopped.");
   clear_on_a_a: assert property (
      match_a && !pwm_mode && ctrl1_r.clear_sel && !en_rise |=> counter_r == 16'h0000)
      else $error("Match A with clear select did not clear.");
   period_clear_a: assert property (
      match_p && !pwm_mode && !ctrl1_r.clear_sel && !en_rise |=> counter_r == 16'h0000)
      else $error("Match P or overflow did not clear the counter.");
   pair_write_a: assert property (
      wr_cmpa_hi |=> cmpa_r == {$past(w_data_r), $past(buffer_r)})
      else $error("High byte write did not take buffer into low byte.");
   high_read_a: assert property (
      rd_cnt_hi && !wr_cmpa_lo |=> {rdata_r[7:0], buffer_r} == $past(counter_r))
      else $error("Counter high read wrong or buffer not loaded.");
   pin_edge_a: assert property (
      run && ctrl0_r.clk_sel == timer_pkg::CLK_PIN_FALL && !sp_mode && pin_fall |-> tick)
      else $error("Falling pin edge not counted.");
   set_high_a: assert property (
      match_a && !en_rise && ctrl1_r.mode == timer_pkg::MODE_COMPARE
      && ctrl1_r.pin_action == timer_pkg::ACT_HIGH |=> wave_r && pin_r == !ctrl1_r.polarity)
      else $error("Compare match did not drive the pin high.");
   match_event_a: assert property (
      match_p |=> match_p_event ##1 (!match_p_event || $past(match_p)))
      else $error("Match P event missing or held.");
   write_answer_a: assert property (
      do_write |=> bvalid_r && bresp_r == ($past(wr_hit) ? timer_pkg::RESP_OKAY
                                                         : timer_pkg::RESP_SLVERR))
      else $error("Write answer missing or wrong response.");

   cover_match_a_c:  cover property (match_a && ctrl1_r.mode == timer_pkg::MODE_COMPARE);
   cover_pwm_c:      cover property (pwm_mode && clear_hit ##1 timer_wave_pin);
   cover_single_c:   cover property (sp_start ##[1:300] (sp_mode && match_a));
   cover_read_pair_c: cover property (rd_cmpa_hi ##[1:20] rd_low);

endmodule

// file: rtl/timer_pkg.sv
package timer_pkg;

   // Byte addresses of the registers, one aligned word each.
   localparam logic [7:0] OFF_CTRL0     = 8'h00;
   localparam logic [7:0] OFF_CTRL1     = 8'h04;
   localparam logic [7:0] OFF_COUNT_LO  = 8'h08;
   localparam logic [7:0] OFF_COUNT_HI  = 8'h0C;
   localparam logic [7:0] OFF_CMPA_LO   = 8'h10;
   localparam logic [7:0] OFF_CMPA_HI   = 8'h14;
   localparam logic [7:0] OFF_PERIOD    = 8'h18;

   // Values after reset.
   localparam logic [7:0]  CTRL0_RST    = 8'h00;
   localparam logic [7:0]  CTRL1_RST    = 8'h00;
   localparam logic [15:0] COUNT_RST    = 16'h0000;
   localparam logic [15:0] CMPA_RST     = 16'h0000;
   localparam logic [7:0]  PERIOD_RST   = 8'h00;
   localparam logic [7:0]  BUFFER_RST   = 8'h00;
   localparam logic [5:0]  PRESC_RST    = 6'h00;

   // Prescaler terminal counts for the divided internal clocks.
   localparam logic [5:0]  DIV4_MASK    = 6'h03;
   localparam logic [5:0]  DIV16_MASK   = 6'h0F;
   localparam logic [5:0]  DIV64_MASK   = 6'h3F;

   // Clock select codes.
   localparam logic [2:0] CLK_SYS_DIV4  = 3'h0;
   localparam logic [2:0] CLK_SYS       = 3'h1;
   localparam logic [2:0] CLK_H_DIV16   = 3'h2;
   localparam logic [2:0] CLK_H_DIV64   = 3'h3;
   localparam logic [2:0] CLK_SUB_A     = 3'h4;
   localparam logic [2:0] CLK_SUB_B     = 3'h5;
   localparam logic [2:0] CLK_PIN_RISE  = 3'h6;
   localparam logic [2:0] CLK_PIN_FALL  = 3'h7;

   // Pin action codes, compare match output mode and PWM modes.
   localparam logic [1:0] ACT_NONE      = 2'h0;
   localparam logic [1:0] ACT_LOW       = 2'h1;
   localparam logic [1:0] ACT_HIGH      = 2'h2;
   localparam logic [1:0] ACT_TOGGLE    = 2'h3;
   localparam logic [1:0] PWM_INACTIVE  = 2'h0;
   localparam logic [1:0] PWM_ACTIVE    = 2'h1;
   localparam logic [1:0] PWM_WAVE      = 2'h2;
   localparam logic [1:0] PWM_SINGLE    = 2'h3;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   typedef enum logic [1:0] {
      MODE_COMPARE = 2'h0,
      MODE_UNDEF   = 2'h1,
      MODE_PWM     = 2'h2,
      MODE_TIMER   = 2'h3
   } mode_type;

   typedef struct packed {
      logic       pause;
      logic [2:0] clk_sel;
      logic       enable;
      logic [2:0] unused;
   } ctrl0_type;

   typedef struct packed {
      mode_type   mode;
      logic [1:0] pin_action;
      logic       init_level;
      logic       polarity;
      logic       swap;
      logic       clear_sel;
   } ctrl1_type;

endpackage

// file: sim/ext_source.sv
// Stands in for the external clock or trigger source and the load on the output pin.
module ext_source (
   input  wire logic clock,
   output logic      timer_clock_pin,
   input  wire logic timer_wave_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   // pin routing: the pins are taken as already routed to the timer.
   initial timer_clock_pin = 1'b0;

   // Each pulse gives one rising and one falling edge, three cycles apart.
   // The pin is held idle low between pulses, so no stray edge reaches the timer.
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clock);
         timer_clock_pin <= 1'b1;
         repeat (3) @(posedge clock);
         timer_clock_pin <= 1'b0;
         repeat (3) @(posedge clock);
      end
   endtask
endmodule

// file: sim/standard_timer_bench.sv
module standard_timer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 1'b0, rst_n = 1'b0, sub_clock_tick = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, timer_clock_pin;
   logic        timer_wave_pin, match_a_event, match_p_event;
   logic [1:0]  bresp, rresp, rr, br;
   logic [31:0] rdata, rv;
   logic [15:0] cv;
   logic [4:0]  sub_cnt = 5'h00;
   int          bad_count = 0, cmp_count = 0, a_seen = 0, p_seen = 0, hi_cnt = 0, n, h;
   int          div[6] = '{4, 1, 16, 64, 8, 8};

   always #25 clock = ~clock;

   // Sub clock ticks every eight cycles; event and pin-high counts feed the checks.
   always @(posedge clock) begin
      sub_cnt <= sub_cnt + 5'h01;
      sub_clock_tick <= (sub_cnt[2:0] == 3'h7);
      a_seen <= a_seen + int'(match_a_event === 1'b1);
      p_seen <= p_seen + int'(match_p_event === 1'b1);
      hi_cnt <= hi_cnt + int'(timer_wave_pin === 1'b1);
   end

   standard_timer dut (.clock(clock), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .sub_clock_tick(sub_clock_tick), .timer_clock_pin(timer_clock_pin),
      .timer_wave_pin(timer_wave_pin), .match_a_event(match_a_event),
      .match_p_event(match_p_event));

   ext_source src (.clock(clock), .timer_clock_pin(timer_clock_pin),
      .timer_wave_pin(timer_wave_pin));

   // Handshakes are judged at the falling edge, so the rising edge never races the design.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic at, wt, bt;
      awaddr <= a; wdata <= {24'h000000, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      bt = 1'b0;
      while (!bt) begin
         @(negedge clock);
         at = awvalid & awready; wt = wvalid & wready; bt = bvalid;
         br = bresp;
         @(posedge clock);
         if (at) awvalid <= 1'b0;
         if (wt) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rd(input logic [7:0] a);
      logic at, t;
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1; t = 1'b0;
      while (!t) begin
         @(negedge clock);
         at = arvalid & arready; t = rvalid; rv = rdata; rr = rresp;
         @(posedge clock);
         if (at) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rd16(input logic [7:0] hi, input logic [7:0] lo);
      rd(hi);
      cv[15:8] = rv[7:0];
      rd(lo);
      cv[7:0] = rv[7:0];
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic rng(input logic [15:0] v, input int lo, input int hi);
      cmp_count++;
      if ($isunknown(v) || v < lo || v > hi) begin
         bad_count++;
         $display("wrong value at %0t: %h outside %0d..%0d", $time, v, lo, hi);
      end
   endtask

   task automatic complete_run;
      if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      #1000000;
      bad_count++;
      complete_run;
   end

   initial begin
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      // Every register reads zero after reset; an unmapped word is refused.
      for (int i = 0; i < 7; i++) begin
         rd(timer_pkg::OFF_CTRL0 + 8'(4 * i));
         chk(rv, 32'h00000000); // reset values
      end
      rd(8'h1C);
      chk({30'h0, rr}, {30'h0, timer_pkg::RESP_SLVERR}); // unmapped read
      wr(8'h1C, 8'h00);
      chk({30'h0, br}, {30'h0, timer_pkg::RESP_SLVERR}); // unmapped write
      // Low byte goes through the buffer; the counter pair ignores writes.
      wr(timer_pkg::OFF_CMPA_LO, 8'h34); // low first
      wr(timer_pkg::OFF_CMPA_HI, 8'h12); // then high
      wr(timer_pkg::OFF_COUNT_HI, 8'hFF);
      chk({30'h0, br}, {30'h0, timer_pkg::RESP_OKAY}); // ignored write answered OKAY
      rd16(timer_pkg::OFF_CMPA_HI, timer_pkg::OFF_CMPA_LO); // high then low
      chk({16'h0, cv}, 32'h00001234); // buffered pair
      rd16(timer_pkg::OFF_COUNT_HI, timer_pkg::OFF_COUNT_LO);
      chk({16'h0, cv}, 32'h00000000); // counter read only
      // Each internal source counts for a fixed span; the count is then held.
      for (int c = 0; c < 6; c++) begin
         wr(timer_pkg::OFF_CTRL0, {1'b0, 3'(c), 4'h8}); // clock code
         repeat (130) @(posedge clock);
         wr(timer_pkg::OFF_CTRL0, {1'b0, 3'(c), 4'h0});
         rd16(timer_pkg::OFF_COUNT_HI, timer_pkg::OFF_COUNT_LO);
         rng(cv, 130 / div[c] - 1, 140 / div[c] + 1); // rate per source
         h = cv;
         repeat (20) @(posedge clock);
         rd16(timer_pkg::OFF_COUNT_HI, timer_pkg::OFF_COUNT_LO);
         chk(32'(cv), 32'(h)); // disabled counter holds
      end
      // Enabling while paused clears the counter and leaves it still.
      wr(timer_pkg::OFF_CTRL0, 8'h98);
      repeat (20) @(posedge clock);
      rd16(timer_pkg::OFF_COUNT_HI, timer_pkg::OFF_COUNT_LO);
      chk({16'h0, cv}, 32'h00000000); // clear by enable
      // Pin edges clock the counter; match A drives the pin and clears the counter.
      wr(timer_pkg::OFF_CMPA_LO, 8'h03);
      wr(timer_pkg::OFF_CMPA_HI, 8'h00);
      for (int k = 1; k < 4; k++) begin
         wr(timer_pkg::OFF_CTRL0, 8'h00);
         wr(timer_pkg::OFF_CTRL1, {4'(k), 1'(k == 1), 1'(k == 3), 2'h1}); // clear on A
         wr(timer_pkg::OFF_CTRL0, {1'b0, (k == 2) ? 3'h7 : 3'h6, 4'h8});
         repeat (3) @(posedge clock);
         chk(32'(timer_wave_pin), 32'(k != 2)); // initial level
         n = a_seen;
         src.pulses(3);
         repeat (4) @(posedge clock);
         chk(32'(timer_wave_pin), 32'(k == 2)); // pin action
         chk(32'(a_seen - n), 32'h1); // full compare
         rd16(timer_pkg::OFF_COUNT_HI, timer_pkg::OFF_COUNT_LO);
         chk({16'h0, cv}, 32'h00000000); // match clears
      end
      wr(timer_pkg::OFF_CTRL0, 8'h00);
      wr(timer_pkg::OFF_CTRL0, 8'h68);
      repeat (3) @(posedge clock);
      chk(32'(timer_wave_pin), 32'h1); // pin restored
      // Period compare checks the top byte with a zero low byte: one match in 256 ticks.
      wr(timer_pkg::OFF_CTRL0, 8'h00);
      wr(timer_pkg::OFF_CTRL1, 8'hC0); // timer mode
      wr(timer_pkg::OFF_PERIOD, 8'h01);
      n = p_seen;
      wr(timer_pkg::OFF_CTRL0, 8'h18);
      repeat (300) @(posedge clock);
      chk(32'(p_seen - n), 32'h1); // period match
      rd16(timer_pkg::OFF_COUNT_HI, timer_pkg::OFF_COUNT_LO);
      chk({24'h0, cv[15:8]}, 32'h00000000); // cleared by P
      // Wave mode: duty 0x40 in a period of 256, so a quarter of the time active.
      wr(timer_pkg::OFF_CTRL0, 8'h00);
      wr(timer_pkg::OFF_CMPA_LO, 8'h40);
      wr(timer_pkg::OFF_CMPA_HI, 8'h00);
      wr(timer_pkg::OFF_CTRL1, 8'hA8);
      wr(timer_pkg::OFF_CTRL0, 8'h18);
      repeat (300) @(posedge clock);
      h = hi_cnt;
      repeat (512) @(posedge clock);
      chk(32'(hi_cnt - h), 32'd128); // wave duty
      // Single pulse: a pin rising edge starts a pulse that lasts until match A.
      wr(timer_pkg::OFF_CTRL0, 8'h00);
      wr(timer_pkg::OFF_CMPA_LO, 8'h05);
      wr(timer_pkg::OFF_CMPA_HI, 8'h00);
      wr(timer_pkg::OFF_CTRL1, 8'hB8); // pulse mode
      wr(timer_pkg::OFF_CTRL0, 8'h18);
      repeat (20) @(posedge clock);
      h = hi_cnt;
      src.pulses(1);
      repeat (30) @(posedge clock);
      rng(16'(hi_cnt - h), 4, 7); // triggered pulse
      complete_run;
   end
endmodule
